// ==== core/tcc_pkg.sv ====
// Purpose: shared constants for the two-channel capture/compare timer core
// Assumes: register index = printed offset, byte address = index * 4
// Notes: each register except the 16-bit counter word holds one byte in the low lanes of a 32-bit word
package tcc_pkg;

   // bus and datapath widths
   localparam int DATA_W = 32;
   localparam int IDX_W = 8;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 16;
   localparam int PRE_W = 8;
   localparam int LEG_W = 3;

   // register indices
   localparam logic [IDX_W-1:0] IDX_DIR = 8'h00;
   localparam logic [IDX_W-1:0] IDX_FORCE = 8'h01;
   localparam logic [IDX_W-1:0] IDX_CNT_HI = 8'h04;
   localparam logic [IDX_W-1:0] IDX_CNT_LO = 8'h05;
   localparam logic [IDX_W-1:0] IDX_CTRL1 = 8'h06;
   localparam logic [IDX_W-1:0] IDX_TOV = 8'h07;
   localparam logic [IDX_W-1:0] IDX_ACTION = 8'h09;
   localparam logic [IDX_W-1:0] IDX_CTRL2 = 8'h0d;
   localparam logic [IDX_W-1:0] IDX_CHFLAG = 8'h0e;
   localparam logic [IDX_W-1:0] IDX_WRAPFLAG = 8'h0f;
   localparam logic [IDX_W-1:0] IDX_VAL_BASE = 8'h10;
   localparam logic [IDX_W-1:0] IDX_FINE_DIV = 8'h2e;
   localparam logic [IDX_W-1:0] IDX_CNT_WORD = 8'h30;

   // control_one field positions
   localparam int BIT_RUN = 7;
   localparam int BIT_HALT_WAIT = 6;
   localparam int BIT_HALT_FRZ = 5;
   localparam int BIT_FAST_CLR = 4;
   localparam int BIT_FINE_SEL = 3;
   // wrap flag position in its register
   localparam int BIT_WRAP = 7;

   // reset values
   localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
   localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
   localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
   localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
   localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

   // output action codes {mode, level}
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

   // next pin level for an output action
   function automatic logic tcc_act_apply(input logic [1:0] act, input logic cur);
      unique case (act)
         ACT_NONE: tcc_act_apply = cur;
         ACT_TOGGLE: tcc_act_apply = ~cur;
         ACT_CLEAR: tcc_act_apply = 1'b0;
         ACT_SET: tcc_act_apply = 1'b1;
      endcase
   endfunction : tcc_act_apply

endpackage : tcc_pkg

// ==== core/tcc_prescaler.sv ====
// Purpose: timer clock prescaler, legacy power-of-two or fine divide-by-n+1
// Assumes: selection inputs come from registers on the same clock
// Notes: a new factor takes effect at once, compared against the running stage count
`timescale 1ns/1ps
module tcc_prescaler
   import tcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic run_i,
   input wire logic fine_sel_i,
   input wire logic [tcc_pkg::LEG_W-1:0] legacy_sel_i,
   input wire logic [tcc_pkg::PRE_W-1:0] fine_div_i,
   output logic tick_o
);
   import tcc_pkg::*;

   logic [PRE_W-1:0] stage_reg;
   logic [PRE_W-1:0] limit;
   logic hit;

   // terminal count: 2^sel - 1 in legacy mode, the fine_div_i byte in fine mode
   always_comb
   begin
      if (fine_sel_i)
      begin
         limit = fine_div_i;
      end
      else
      begin
         limit = (PRE_ONE << legacy_sel_i) - PRE_ONE;
      end
      hit = (stage_reg >= limit);
   end

   // stage counter holds while the timer is halted
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         stage_reg <= PRE_ZERO;
      end
      else if (run_i)
      begin
         stage_reg <= hit ? PRE_ZERO : stage_reg + PRE_ONE;
      end
   end

   // one-cycle count pulse
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         tick_o <= 1'b0;
      end
      else
      begin
         tick_o <= run_i & hit;
      end
   end

endmodule : tcc_prescaler

// ==== core/tcc_top.sv ====
// Purpose: core control of a small capture/compare timer, reached over APB
// Assumes: mode inputs are on clk_i; capture pins are asynchronous
// Notes: zero-wait slave; byte registers sit in the low lanes of each word
// Function
// - force strobe register always reads zero
// - force bit performs the programmed compare action
// - forced action never sets the event flag
// - force beats real match, flag stays clear
// - unimplemented channel bits ignore writes, read zero
// - main counter is 16-bit, prescaled up counter
// - counter writes only take effect in special mode
// - first period after counter write may vary
// - run enable bit halts the whole timer
// - halt-in-wait stops timer during wait mode
// - halt-in-freeze stops counter during freeze mode
// - fast clear on channel value access clears flag
// - fast clear on counter access clears wrap flag
// - divider select picks legacy or fine prescaler
// - divider select bit accepts only first write
// - overflow toggle flips compare pin on wrap
// - overflow toggle beats forced compare action
// - direction bit: zero capture, one compare
// - action field: none, toggle, clear, set
// - legacy divider gives divide by 1 to 128
// - event flag clears by writing one while running
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module tcc_top
   import tcc_pkg::*;
#(
   parameter int N_CHAN = 2,
   parameter int ADDR_W = 12
)
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [tcc_pkg::DATA_W-1:0] pwdata_i,
   output logic [tcc_pkg::DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic special_mode_i,
   input wire logic wait_mode_i,
   input wire logic freeze_mode_i,
   input wire logic [N_CHAN-1:0] cap_pin_i,
   output logic [N_CHAN-1:0] cmp_line_o,
   output logic [N_CHAN-1:0] cmp_oe_b_o,
   output logic timer_active_o
);
   import tcc_pkg::*;

   // refuse layouts that the one-byte fields cannot hold
   if (N_CHAN < 1 || N_CHAN > 4) begin : g_bad_chan
      $error("tcc_top: N_CHAN must be 1 to 4");
   end
   if (ADDR_W < IDX_W + 2) begin : g_bad_addr
      $error("tcc_top: ADDR_W too small for the register map");
   end

   logic [N_CHAN-1:0] dir_reg;
   logic [N_CHAN-1:0] tov_reg;
   logic [2*N_CHAN-1:0] act_reg;
   logic run_reg;
   logic halt_wait_reg;
   logic halt_frz_reg;
   logic fast_clr_reg;
   logic fine_sel_reg;
   logic fine_locked_reg;
   logic [LEG_W-1:0] legacy_sel_reg;
   logic [PRE_W-1:0] fine_div_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] val_reg [N_CHAN];
   logic [N_CHAN-1:0] flag_reg;
   logic wrap_reg;
   logic [N_CHAN-1:0] pin_reg;
   logic [N_CHAN-1:0] cap_meta_reg;
   logic [N_CHAN-1:0] cap_sync_reg;
   logic [N_CHAN-1:0] cap_last_reg;

   logic acc;
   logic wr;
   logic rd;
   logic [IDX_W-1:0] idx;
   logic [BYTE_W-1:0] wd;
   logic mapped;
   logic active;
   logic tick;
   logic [CNT_W-1:0] cnt_inc;
   logic wrap_evt;
   logic cnt_acc;
   logic [N_CHAN-1:0] force_hit;
   logic [N_CHAN-1:0] match_hit;
   logic [N_CHAN-1:0] tov_hit;
   logic [N_CHAN-1:0] cap_hit;
   logic [N_CHAN-1:0] fast_hit;

   // true when index a addresses either byte of channel ch's value
   function automatic logic val_sel(input logic [IDX_W-1:0] a, input int ch);
      logic [IDX_W-1:0] base;
      base = IDX_VAL_BASE + IDX_W'(2 * ch);
      val_sel = (a[IDX_W-1:1] == base[IDX_W-1:1]);
   endfunction : val_sel

   // apb access phase decode
   assign acc = psel_i & penable_i;
   assign wr = acc & pwrite_i;
   assign rd = acc & ~pwrite_i;
   assign idx = paddr_i[IDX_W+1:2];
   assign wd = pwdata_i[BYTE_W-1:0];
   assign pready_o = 1'b1;
   assign pslverr_o = acc & ~mapped;

   // run qualification for the whole timer
   assign active = run_reg & ~(wait_mode_i & halt_wait_reg)
      & ~(freeze_mode_i & halt_frz_reg);
   assign timer_active_o = active;

   // prescaler keeps running across counter writes, so no realignment
   tcc_prescaler u_tcc_prescaler (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .run_i(active),
      .fine_sel_i(fine_sel_reg),
      .legacy_sel_i(legacy_sel_reg),
      .fine_div_i(fine_div_reg),
      .tick_o(tick)
   );

   // counter and per-channel events
   assign cnt_inc = cnt_reg + CNT_ONE;
   assign wrap_evt = tick & (cnt_reg == CNT_MAX);
   assign cnt_acc = acc & (idx == IDX_CNT_HI || idx == IDX_CNT_LO || idx == IDX_CNT_WORD);
   for (genvar i = 0; i < N_CHAN; i++) begin : g_evt
      assign force_hit[i] = wr & (idx == IDX_FORCE) & wd[i] & dir_reg[i];
      assign match_hit[i] = tick & dir_reg[i] & (cnt_inc == val_reg[i]);
      assign tov_hit[i] = wrap_evt & tov_reg[i] & dir_reg[i];
      assign cap_hit[i] = active & ~dir_reg[i] & (cap_sync_reg[i] ^ cap_last_reg[i]);
      assign fast_hit[i] = fast_clr_reg & val_sel(idx, i)
         & ((rd & ~dir_reg[i]) | (wr & dir_reg[i]));
   end

   // direction, toggle, action and divider registers
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         dir_reg <= '0;
         tov_reg <= '0;
         act_reg <= '0;
         legacy_sel_reg <= '0;
         fine_div_reg <= RST_BYTE;
      end
      else if (wr)
      begin
         unique case (idx)
            IDX_DIR: dir_reg <= wd[N_CHAN-1:0];
            IDX_TOV: tov_reg <= wd[N_CHAN-1:0];
            IDX_ACTION: act_reg <= wd[2*N_CHAN-1:0];
            IDX_CTRL2: legacy_sel_reg <= wd[LEG_W-1:0];
            IDX_FINE_DIV: fine_div_reg <= wd;
            default: ;
         endcase
      end
   end

   // control_one, with the divider select taken once per reset
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         run_reg <= 1'b0;
         halt_wait_reg <= 1'b0;
         halt_frz_reg <= 1'b0;
         fast_clr_reg <= 1'b0;
         fine_sel_reg <= 1'b0;
         fine_locked_reg <= 1'b0;
      end
      else if (wr && idx == IDX_CTRL1)
      begin
         run_reg <= wd[BIT_RUN];
         halt_wait_reg <= wd[BIT_HALT_WAIT];
         halt_frz_reg <= wd[BIT_HALT_FRZ];
         fast_clr_reg <= wd[BIT_FAST_CLR];
         fine_locked_reg <= 1'b1;
         if (!fine_locked_reg)
            fine_sel_reg <= wd[BIT_FINE_SEL];
      end
   end

   // main counter: special-mode loads win over the count pulse
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
         cnt_reg <= RST_CNT;
      else if (wr && special_mode_i && idx == IDX_CNT_WORD)
         cnt_reg <= pwdata_i[CNT_W-1:0];
      else if (wr && special_mode_i && idx == IDX_CNT_HI)
         cnt_reg <= {wd, cnt_reg[BYTE_W-1:0]};
      else if (wr && special_mode_i && idx == IDX_CNT_LO)
         cnt_reg <= {cnt_reg[CNT_W-1:BYTE_W], wd};
      else if (tick)
         cnt_reg <= cnt_inc;
   end

   // capture pin synchronisers and edge memory
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         cap_meta_reg <= '0;
         cap_sync_reg <= '0;
         cap_last_reg <= '0;
      end
      else
      begin
         cap_meta_reg <= cap_pin_i;
         cap_sync_reg <= cap_meta_reg;
         cap_last_reg <= cap_sync_reg;
      end
   end

   // per-channel value, flag and compare pin
   for (genvar i = 0; i < N_CHAN; i++) begin : g_chan
      always_ff @(posedge clk_i)
      begin
         if (!rst_b_i)
            val_reg[i] <= RST_CNT;
         else if (cap_hit[i])
            val_reg[i] <= cnt_reg;
         else if (wr && val_sel(idx, i))
            val_reg[i] <= idx[0] ? {val_reg[i][CNT_W-1:BYTE_W], wd}
               : {wd, val_reg[i][BYTE_W-1:0]};
      end

      // set beats clear; a forced action suppresses the match flag
      always_ff @(posedge clk_i)
      begin
         if (!rst_b_i)
            flag_reg[i] <= 1'b0;
         else if ((match_hit[i] && !force_hit[i]) || cap_hit[i])
            flag_reg[i] <= 1'b1;
         else if ((wr && idx == IDX_CHFLAG && wd[i] && run_reg) || fast_hit[i])
            flag_reg[i] <= 1'b0;
      end

      // overflow toggle first, then forced or matched action
      always_ff @(posedge clk_i)
      begin
         if (!rst_b_i)
            pin_reg[i] <= 1'b0;
         else if (tov_hit[i])
            pin_reg[i] <= ~pin_reg[i];
         else if (force_hit[i] || match_hit[i])
            pin_reg[i] <= tcc_act_apply(act_reg[2*i+1:2*i], pin_reg[i]);
      end

      // pin is driven while the channel compares with an action or overflow toggle set
      assign cmp_oe_b_o[i] = ~(dir_reg[i] & ((act_reg[2*i+1:2*i] != ACT_NONE) | tov_reg[i]));
   end
   assign cmp_line_o = pin_reg;

   // wrap flag: set wins, cleared by writing one while running or by fast clear
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
         wrap_reg <= 1'b0;
      else if (wrap_evt)
         wrap_reg <= 1'b1;
      else if ((wr && idx == IDX_WRAPFLAG && wd[BIT_WRAP] && run_reg)
         || (fast_clr_reg && cnt_acc))
         wrap_reg <= 1'b0;
   end

   // read mux and unmapped detection
   always_comb
   begin
      prdata_o = RD_ZERO;
      mapped = 1'b1;
      unique case (idx)
         IDX_DIR: prdata_o[N_CHAN-1:0] = dir_reg;
         IDX_FORCE: prdata_o = RD_ZERO;
         IDX_CNT_HI: prdata_o[BYTE_W-1:0] = cnt_reg[CNT_W-1:BYTE_W];
         IDX_CNT_LO: prdata_o[BYTE_W-1:0] = cnt_reg[BYTE_W-1:0];
         IDX_CNT_WORD: prdata_o[CNT_W-1:0] = cnt_reg;
         IDX_CTRL1:
         begin
            prdata_o[BIT_RUN] = run_reg;
            prdata_o[BIT_HALT_WAIT] = halt_wait_reg;
            prdata_o[BIT_HALT_FRZ] = halt_frz_reg;
            prdata_o[BIT_FAST_CLR] = fast_clr_reg;
            prdata_o[BIT_FINE_SEL] = fine_sel_reg;
         end
         IDX_TOV: prdata_o[N_CHAN-1:0] = tov_reg;
         IDX_ACTION: prdata_o[2*N_CHAN-1:0] = act_reg;
         IDX_CTRL2: prdata_o[LEG_W-1:0] = legacy_sel_reg;
         IDX_CHFLAG: prdata_o[N_CHAN-1:0] = flag_reg;
         IDX_WRAPFLAG: prdata_o[BIT_WRAP] = wrap_reg;
         IDX_FINE_DIV: prdata_o[PRE_W-1:0] = fine_div_reg;
         default:
         begin
            mapped = 1'b0;
            for (int c = 0; c < N_CHAN; c++)
            begin
               if (val_sel(idx, c))
               begin
                  mapped = 1'b1;
                  prdata_o[BYTE_W-1:0] = idx[0] ? val_reg[c][BYTE_W-1:0]
                     : val_reg[c][CNT_W-1:BYTE_W];
               end
            end
         end
      endcase
   end

   // checks on the block's own behaviour
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_halted;
      !active [*2];
   endsequence
   sequence s_no_load;
      !(wr && special_mode_i && (idx == IDX_CNT_HI || idx == IDX_CNT_LO || idx == IDX_CNT_WORD));
   endsequence

   a_force_read_zero: assert property (rd && idx == IDX_FORCE |-> prdata_o == RD_ZERO)
      else $error("force strobe register read nonzero");
   a_force_sets_pin: assert property (force_hit[0] && !tov_hit[0]
      && act_reg[1:0] == ACT_SET |=> cmp_line_o[0])
      else $error("forced set action did not raise the pin");
   a_force_no_flag: assert property (force_hit[0] && !flag_reg[0] && !cap_hit[0]
      |=> !flag_reg[0])
      else $error("forced compare set the event flag");
   a_count_step: assert property (tick && !wr |=> cnt_reg == $past(cnt_inc))
      else $error("counter did not advance on the count pulse");
   a_count_guard: assert property (wr && !special_mode_i && !tick && idx == IDX_CNT_WORD
      |=> $stable(cnt_reg))
      else $error("counter write took effect outside special mode");
   a_halt_holds: assert property (s_halted ##0 s_no_load |=> $stable(cnt_reg))
      else $error("counter moved while the timer was halted");
   a_wait_stop: assert property (wait_mode_i && halt_wait_reg |-> !active ##1 !tick)
      else $error("timer ran in wait mode with halt set");
   a_freeze_stop: assert property (freeze_mode_i && halt_frz_reg |-> !active)
      else $error("timer ran in freeze mode with halt set");
   a_select_lock: assert property (fine_locked_reg && wr && idx == IDX_CTRL1
      |=> fine_sel_reg == $past(fine_sel_reg))
      else $error("divider select changed after its first write");
   a_wrap_sets: assert property (wrap_evt ##0 s_no_load |=> wrap_reg && cnt_reg == RST_CNT)
      else $error("wrap did not set the flag or reset the count");
   a_tov_flips: assert property (tov_hit[0] |=> cmp_line_o[0] != $past(cmp_line_o[0]))
      else $error("overflow toggle did not flip the pin");

endmodule : tcc_top

// ==== dv/tcc_pin_model.sv ====
// Purpose: model of the channel pins outside the timer core
// Assumes: the bench asks for one capture edge at a time, one cycle long
// Notes: counts every level change seen on each compare output line
`timescale 1ns/1ps
module tcc_pin_model #(
   parameter int N_CHAN = 2
)
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [N_CHAN-1:0] edge_req_i,
   input wire logic [N_CHAN-1:0] cmp_line_i,
   output logic [N_CHAN-1:0] cap_pin_o,
   output logic [N_CHAN-1:0][7:0] chg_cnt_o
);
   logic [N_CHAN-1:0] last_line;

   // outside source flips a capture pin when asked
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
         cap_pin_o <= '0;
      else
         cap_pin_o <= cap_pin_o ^ edge_req_i;
   end

   // tally level changes on the compare lines
   always_ff @(posedge clk_i)
   begin
      last_line <= cmp_line_i;
      for (int i = 0; i < N_CHAN; i++)
      begin
         if (!rst_b_i)
            chg_cnt_o[i] <= 8'h00;
         else if (cmp_line_i[i] !== last_line[i])
            chg_cnt_o[i] <= chg_cnt_o[i] + 8'h01;
      end
   end
endmodule : tcc_pin_model

// ==== dv/tb_timer_core_control.sv ====
// Purpose: self-checking bench for the timer core over its register bus
// Assumes: zero-wait slave; counter word readable at its own index
// Notes: count rates come from two word reads exactly 128 cycles apart
`timescale 1ns/1ps
module tb_timer_core_control;
   import tcc_pkg::*;
   logic clk, rst_b, psel, penable, pwrite, special, wait_md, frz_md, last_err;
   logic pready, pslverr, active;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, a;
   logic [1:0] cap_pin, cmp_line, cmp_oe_b, edge_req;
   logic [1:0][7:0] chg_cnt;
   int mismatches, cmp_count;

   // design and the pins beyond it
   tcc_top u_tcc_top (.clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .special_mode_i(special),
      .wait_mode_i(wait_md), .freeze_mode_i(frz_md), .cap_pin_i(cap_pin),
      .cmp_line_o(cmp_line), .cmp_oe_b_o(cmp_oe_b), .timer_active_o(active));
   tcc_pin_model u_tcc_pin_model (.clk_i(clk), .rst_b_i(rst_b), .edge_req_i(edge_req),
      .cmp_line_i(cmp_line), .cap_pin_o(cap_pin), .chg_cnt_o(chg_cnt));

   // 50 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   // one bus transfer: setup, access held until ready, then release
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // ready and the answer are taken at the same rising edge
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         mismatches++;
         stop_test();
      end
   endtask : xfer

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, {24'h0, d});
   endtask : wr

   task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, RD_ZERO);
      check(name, rd, exp);
   endtask : rchk

   task automatic do_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
   endtask : do_reset

   task automatic pulse_cap();
      @(posedge clk);
      edge_req <= 2'b01;
      @(posedge clk);
      edge_req <= 2'b00;
      repeat (8) @(posedge clk);
   endtask : pulse_cap

   // set modes and control, then count steps over 128 cycles
   task automatic measure(input logic [7:0] ctl, input logic w, input logic f,
                          input logic [15:0] exp);
      @(posedge clk);
      wait_md <= w;
      frz_md <= f;
      wr(IDX_CTRL1, ctl);
      repeat (260) @(posedge clk);
      xfer(1'b0, IDX_CNT_WORD, RD_ZERO);
      a = rd;
      repeat (125) @(posedge clk);
      xfer(1'b0, IDX_CNT_WORD, RD_ZERO);
      check("count step", {16'h0, rd[15:0] - a[15:0]}, {16'h0, exp});
      check("active", {31'h0, active}, {31'h0, exp != 16'h0});
   endtask : measure

   task automatic sc_reset();
      rchk("dir", IDX_DIR, RD_ZERO);
      rchk("ctrl1", IDX_CTRL1, RD_ZERO);
      rchk("tov", IDX_TOV, RD_ZERO);
      rchk("wrap flag", IDX_WRAPFLAG, RD_ZERO);
      rchk("unmapped", 8'h02, RD_ZERO);
      check("unmapped err", {31'h0, last_err}, 32'h1);
      check("oe reset", {30'h0, cmp_oe_b}, 32'h3);
   endtask : sc_reset

   task automatic sc_force();
      logic [7:0] acts [3] = '{8'h07, 8'h08, 8'h07};
      logic [7:0] frcs [3] = '{8'hff, 8'h03, 8'h02};
      logic [1:0] lines [3] = '{2'b11, 2'b01, 2'b11};
      wr(IDX_CTRL1, 8'h80);
      wr(IDX_DIR, 8'hff);
      rchk("dir bits", IDX_DIR, 32'h3);
      for (int i = 0; i < 3; i++)
      begin
         wr(IDX_ACTION, acts[i]);
         wr(IDX_FORCE, frcs[i]);
         @(negedge clk);
         check("force line", {30'h0, cmp_line}, {30'h0, lines[i]});
      end
      rchk("force read", IDX_FORCE, RD_ZERO);
      rchk("force flags", IDX_CHFLAG, RD_ZERO);
      check("oe compare", {30'h0, cmp_oe_b}, RD_ZERO);
   endtask : sc_force

   task automatic sc_rates();
      for (int s = 0; s < 8; s++)
      begin
         wr(IDX_CTRL2, 8'(s));
         measure(8'h80, 1'b0, 1'b0, 16'd128 >> s);
      end
      wr(IDX_CTRL2, 8'h00);
      measure(8'h00, 1'b0, 1'b0, 16'd0);
      measure(8'hc0, 1'b1, 1'b0, 16'd0);
      measure(8'hc0, 1'b0, 1'b0, 16'd128);
      measure(8'h80, 1'b1, 1'b0, 16'd128);
      measure(8'ha0, 1'b0, 1'b1, 16'd0);
      measure(8'ha0, 1'b0, 1'b0, 16'd128);
      measure(8'h80, 1'b0, 1'b1, 16'd128);
   endtask : sc_rates

   task automatic sc_wrap();
      wr(IDX_CTRL1, 8'h00);
      xfer(1'b0, IDX_CNT_WORD, RD_ZERO);
      a = rd;
      xfer(1'b1, IDX_CNT_WORD, 32'h1234);
      rchk("normal write", IDX_CNT_WORD, a);
      @(posedge clk);
      special <= 1'b1;
      xfer(1'b1, IDX_CNT_WORD, 32'hfff0);
      special <= 1'b0;
      rchk("special write", IDX_CNT_WORD, 32'hfff0);
      wr(IDX_ACTION, 8'h00);
      wr(IDX_TOV, 8'h02);
      a = {24'h0, chg_cnt[1]};
      wr(IDX_CTRL1, 8'h80);
      repeat (40) @(posedge clk);
      rchk("wrap flag set", IDX_WRAPFLAG, 32'h80);
      @(negedge clk);
      check("toggle on wrap", {24'h0, chg_cnt[1]}, a + 32'h1);
      wr(IDX_CTRL1, 8'h90);
      xfer(1'b0, IDX_CNT_HI, RD_ZERO);
      rchk("fast wrap clear", IDX_WRAPFLAG, RD_ZERO);
   endtask : sc_wrap

   task automatic sc_capture();
      wr(IDX_DIR, 8'h02);
      wr(IDX_CHFLAG, 8'h03);
      rchk("flags cleared", IDX_CHFLAG, RD_ZERO);
      pulse_cap();
      xfer(1'b0, IDX_CHFLAG, RD_ZERO);
      check("capture flag", rd & 32'h1, 32'h1);
      xfer(1'b0, IDX_VAL_BASE + 8'h01, RD_ZERO);
      xfer(1'b0, IDX_CHFLAG, RD_ZERO);
      check("fast flag clear", rd & 32'h1, RD_ZERO);
      pulse_cap();
      wr(IDX_CTRL1, 8'h80);
      wr(IDX_CHFLAG, 8'h00);
      xfer(1'b0, IDX_CHFLAG, RD_ZERO);
      check("zero write keeps", rd & 32'h1, 32'h1);
      wr(IDX_CHFLAG, 8'h01);
      xfer(1'b0, IDX_CHFLAG, RD_ZERO);
      check("one write clears", rd & 32'h1, RD_ZERO);
   endtask : sc_capture

   task automatic sc_fine();
      do_reset();
      wr(IDX_FINE_DIV, 8'h03);
      measure(8'h88, 1'b0, 1'b0, 16'd32);
      measure(8'h80, 1'b0, 1'b0, 16'd32);
      rchk("select locked", IDX_CTRL1, 32'h88);
   endtask : sc_fine

   // main sequence
   initial
   begin
      {rst_b, psel, penable, pwrite, special, wait_md, frz_md} = '0;
      paddr = '0;
      pwdata = '0;
      edge_req = '0;
      do_reset();
      sc_reset();
      sc_force();
      sc_rates();
      sc_wrap();
      sc_capture();
      sc_fine();
      stop_test();
   end

   // hang guard
   initial
   begin
      repeat (100000) @(posedge clk);
      mismatches++;
      stop_test();
   end
endmodule : tb_timer_core_control
